// ### logic/arlt_defines.svh
// Purpose: offsets, field positions, reset values and counts of the timer
// Assumes: 32-bit bus words, byte addresses
// Notes: definitions only
`ifndef ARLT_DEFINES_SVH
`define ARLT_DEFINES_SVH
// Register byte offsets
`define ARLT_OFS_CTRL 8'h00
`define ARLT_OFS_CNT_LO 8'h04
`define ARLT_OFS_CNT_HI 8'h08
`define ARLT_OFS_RLD_LO 8'h0c
`define ARLT_OFS_RLD_HI 8'h10
`define ARLT_OFS_CLKCTL 8'h14
`define ARLT_OFS_STATUS 8'h18
`define ARLT_OFS_MASK 8'h1c
// Timer control register fields
`define ARLT_B_HI_OVF 7
`define ARLT_B_LO_OVF 6
`define ARLT_B_LO_IEN 5
`define ARLT_B_CAP_EN 4
`define ARLT_B_SPLIT 3
`define ARLT_B_RUN 2
`define ARLT_B_CSS 1
`define ARLT_B_XCLK 0
// Clock control register fields
`define ARLT_B_LO_CSEL 0
`define ARLT_B_HI_CSEL 1
`define ARLT_B_TMR_IEN 2
// Status and mask fields
`define ARLT_S_HI 0
`define ARLT_S_LO 1
`define ARLT_S_CAP 2
// Reset values
`define ARLT_RST_BYTE 8'h00
`define ARLT_RST_EVT 3'h0
// Clock divider terminal counts (divide by 12 and by 8)
`define ARLT_SYS_DIV 4'hb
`define ARLT_EXT_DIV 3'h7
`endif

// ### logic/arlt_pkg.sv
// Purpose: shared types of the timer
// Assumes: nothing
// Notes: constants live in the defines header
package arlt_pkg;
   typedef logic [7:0] arlt_byte_t;
   typedef enum logic [1:0] {
      ARLT_M16, ARLT_MSPLIT, ARLT_MCAP16, ARLT_MCAPSPLIT
   } arlt_mode_e;
endpackage : arlt_pkg

// ### logic/arlt_timer.sv
// Purpose: 16-bit auto-reload timer with oscillator capture
// Assumes: classic Wishbone slave, 10 MHz mclk_i, sync reset
// Notes: one-wait-state bus answer; ext_clk_i and lfo_i are async pins
//
// Overview of operation
// (R1) Count is two byte registers, low, high
// (R2) Clocks: system, system/12, synced external/8
// (R3) 16-bit wrap reloads count, sets high flag
// (R4) Interrupt on each 16-bit overflow when enabled
// (R5) Low-byte wrap interrupts when low enable set
// (R6) Split mode: two 8-bit auto-reload counters
// (R7) Run gates high half only in split
// (R8) Per-half clock select plus shared external select
// (R9) Split wraps set high and low flags
// (R10) Split interrupts: high, or either with enable
// (R11) Flags cleared only by software
// (R12) Software reads both flags to find source
// (R13) Capture enable selects oscillator capture mode
// (R14) 16-bit capture copies count into reload
// (R15) Split capture copies both halves into reload
// (R16) Source select 0 reserved, 1 falling edge
// (R17) Run bit enables counting, else holds
// (R18) Oscillator synced, falling edge one strobe
// (R19) Capture mode wraps to zero, no reload
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`include "arlt_defines.svh"
module arlt_timer
   import arlt_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic ext_clk_i,
   input wire logic lfo_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o
);
   // Mode from split and capture bits
   function automatic arlt_mode_e mode_of(input arlt_byte_t c);
      mode_of = arlt_mode_e'({c[`ARLT_B_CAP_EN], c[`ARLT_B_SPLIT]});
   endfunction : mode_of

   // Write strobe for one register, low lane only
   function automatic logic wr_hit(input logic [7:0] ofs,
                                   input logic [7:0] adr,
                                   input logic go);
      wr_hit = go && (adr == ofs);
   endfunction : wr_hit

   arlt_byte_t ctrl_reg, ctrl_next;
   arlt_byte_t cnt_lo_reg, cnt_lo_next, cnt_hi_reg, cnt_hi_next;
   arlt_byte_t rld_lo_reg, rld_lo_next, rld_hi_reg, rld_hi_next;
   logic [2:0] clkctl_reg, clkctl_next;
   logic [2:0] sts_reg, sts_next, msk_reg, msk_next;
   logic ack_reg, ack_next;
   logic [31:0] dat_reg, dat_next;
   logic [3:0] presc_reg, presc_next;
   logic [2:0] ediv_reg, ediv_next;
   logic ext_s1_reg, ext_s2_reg, ext_d_reg;
   logic lfo_s1_reg, lfo_s2_reg, lfo_d_reg;
   logic tick12, tick_ext, lfo_fall, wr_go;
   logic [1:0] tick;
   logic [1:0] csel;
   logic ev_hi, ev_lo, ev_cap;
   arlt_mode_e mode;

   // (R2) Prescalers; external edges counted only after sync
   always_comb begin
      tick12 = (presc_reg == `ARLT_SYS_DIV);
      presc_next = tick12 ? 4'h0 : presc_reg + 4'h1;
      tick_ext = ext_s2_reg && !ext_d_reg && (ediv_reg == `ARLT_EXT_DIV);
      ediv_next = (ext_s2_reg && !ext_d_reg) ? ediv_reg + 3'h1 : ediv_reg;
      // (R18) Falling oscillator edge, one cycle
      lfo_fall = lfo_d_reg && !lfo_s2_reg;
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         presc_reg <= 4'h0;
         ediv_reg <= 3'h0;
         {ext_s1_reg, ext_s2_reg, ext_d_reg} <= 3'h0;
         {lfo_s1_reg, lfo_s2_reg, lfo_d_reg} <= 3'h0;
      end else begin
         presc_reg <= presc_next;
         ediv_reg <= ediv_next;
         ext_s1_reg <= ext_clk_i; // First stage feeds only the second
         ext_s2_reg <= ext_s1_reg;
         ext_d_reg <= ext_s2_reg;
         lfo_s1_reg <= lfo_i;
         lfo_s2_reg <= lfo_s1_reg;
         lfo_d_reg <= lfo_s2_reg;
      end
   end

   // (R8) Per-half tick: select 1 is every cycle
   assign csel = {clkctl_reg[`ARLT_B_HI_CSEL], clkctl_reg[`ARLT_B_LO_CSEL]};
   for (genvar h = 0; h < 2; h++) begin : g_half
      assign tick[h] = csel[h] ? 1'b1 :
                       (ctrl_reg[`ARLT_B_XCLK] ? tick_ext : tick12);
   end

   // Bus answer one cycle after the request appears
   assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
   always_comb begin
      ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
      dat_next = 32'h0000_0000;
      unique case (wb_adr_i)
         `ARLT_OFS_CTRL: dat_next[7:0] = ctrl_reg;
         `ARLT_OFS_CNT_LO: dat_next[7:0] = cnt_lo_reg;
         `ARLT_OFS_CNT_HI: dat_next[7:0] = cnt_hi_reg;
         `ARLT_OFS_RLD_LO: dat_next[7:0] = rld_lo_reg;
         `ARLT_OFS_RLD_HI: dat_next[7:0] = rld_hi_reg;
         `ARLT_OFS_CLKCTL: dat_next[2:0] = clkctl_reg;
         `ARLT_OFS_STATUS: dat_next[2:0] = sts_reg;
         `ARLT_OFS_MASK: dat_next[2:0] = msk_reg;
         default: dat_next = 32'h0000_0000; // Unmapped reads zero
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   // Counting, flags, capture and registers
   assign mode = mode_of(ctrl_reg);
   always_comb begin
      ev_hi = 1'b0;
      ev_lo = 1'b0;
      cnt_lo_next = cnt_lo_reg;
      cnt_hi_next = cnt_hi_reg;
      unique case (mode)
         ARLT_M16, ARLT_MCAP16: begin
            // (R17) Run bit gates the whole 16-bit count
            if (ctrl_reg[`ARLT_B_RUN] && tick[0]) begin
               ev_lo = (cnt_lo_reg == 8'hff);
               ev_hi = ev_lo && (cnt_hi_reg == 8'hff);
               // (R3) Full wrap reloads, (R19) capture wraps to zero
               if (ev_hi) begin
                  cnt_hi_next = (mode == ARLT_M16) ? rld_hi_reg : 8'h00;
                  cnt_lo_next = (mode == ARLT_M16) ? rld_lo_reg : 8'h00;
               end else begin
                  {cnt_hi_next, cnt_lo_next} =
                     {cnt_hi_reg, cnt_lo_reg} + 16'h0001;
               end
            end
         end
         ARLT_MSPLIT, ARLT_MCAPSPLIT: begin
            // (R7) Low half free-running in split mode
            if (tick[0]) begin
               ev_lo = (cnt_lo_reg == 8'hff);
               // (R6) Split low reload, (R19) zero in capture
               cnt_lo_next = !ev_lo ? cnt_lo_reg + 8'h01 :
                  ((mode == ARLT_MSPLIT) ? rld_lo_reg : 8'h00);
            end
            if (ctrl_reg[`ARLT_B_RUN] && tick[1]) begin
               ev_hi = (cnt_hi_reg == 8'hff);
               cnt_hi_next = !ev_hi ? cnt_hi_reg + 8'h01 :
                  ((mode == ARLT_MSPLIT) ? rld_hi_reg : 8'h00);
            end
         end
      endcase
      // (R13) (R16) Capture only with source select 1
      ev_cap = ctrl_reg[`ARLT_B_CAP_EN] && ctrl_reg[`ARLT_B_CSS] && lfo_fall;
      ctrl_next = ctrl_reg;
      rld_lo_next = rld_lo_reg;
      rld_hi_next = rld_hi_reg;
      clkctl_next = clkctl_reg;
      msk_next = msk_reg;
      // (R1) Each count byte is its own bus register
      if (wr_hit(`ARLT_OFS_CNT_LO, wb_adr_i, wr_go)) begin
         cnt_lo_next = wb_dat_i[7:0];
      end
      if (wr_hit(`ARLT_OFS_CNT_HI, wb_adr_i, wr_go)) begin
         cnt_hi_next = wb_dat_i[7:0];
      end
      if (wr_hit(`ARLT_OFS_CTRL, wb_adr_i, wr_go)) begin
         ctrl_next = wb_dat_i[7:0];
      end
      if (wr_hit(`ARLT_OFS_RLD_LO, wb_adr_i, wr_go)) begin
         rld_lo_next = wb_dat_i[7:0];
      end
      if (wr_hit(`ARLT_OFS_RLD_HI, wb_adr_i, wr_go)) begin
         rld_hi_next = wb_dat_i[7:0];
      end
      if (wr_hit(`ARLT_OFS_CLKCTL, wb_adr_i, wr_go)) begin
         clkctl_next = wb_dat_i[2:0];
      end
      if (wr_hit(`ARLT_OFS_MASK, wb_adr_i, wr_go)) begin
         msk_next = wb_dat_i[2:0];
      end
      // (R14) (R15) Capture beats a same-cycle reload write
      if (ev_cap) begin
         rld_lo_next = cnt_lo_reg;
         rld_hi_next = cnt_hi_reg;
      end
      // (R9) (R11) Hardware only sets flags; set wins
      if (ev_hi) begin
         ctrl_next[`ARLT_B_HI_OVF] = 1'b1;
      end
      if (ev_lo) begin
         ctrl_next[`ARLT_B_LO_OVF] = 1'b1;
      end
      // Sticky status, write one clears, event wins
      sts_next = sts_reg;
      if (wr_hit(`ARLT_OFS_STATUS, wb_adr_i, wr_go)) begin
         sts_next = sts_reg & ~wb_dat_i[2:0];
      end
      // (R5) (R10) Low wraps count only with low enable
      sts_next = sts_next | {ev_cap, ev_lo && ctrl_reg[`ARLT_B_LO_IEN], ev_hi};
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         ctrl_reg <= `ARLT_RST_BYTE;
         cnt_lo_reg <= `ARLT_RST_BYTE;
         cnt_hi_reg <= `ARLT_RST_BYTE;
         rld_lo_reg <= `ARLT_RST_BYTE;
         rld_hi_reg <= `ARLT_RST_BYTE;
         clkctl_reg <= `ARLT_RST_EVT;
         sts_reg <= `ARLT_RST_EVT;
         msk_reg <= `ARLT_RST_EVT;
      end else begin
         ctrl_reg <= ctrl_next;
         cnt_lo_reg <= cnt_lo_next;
         cnt_hi_reg <= cnt_hi_next;
         rld_lo_reg <= rld_lo_next;
         rld_hi_reg <= rld_hi_next;
         clkctl_reg <= clkctl_next;
         sts_reg <= sts_next;
         msk_reg <= msk_next;
      end
   end

   // (R4) Timer enable gates the unmasked sticky events
   assign irq_o = clkctl_reg[`ARLT_B_TMR_IEN] && |(sts_reg & msk_reg);

   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   logic quiet;
   assign quiet = !wr_go;

   sequence s_req;
      wb_cyc_i && wb_stb_i && !ack_reg;
   endsequence
   sequence s_ack_pulse;
      ack_reg ##1 !ack_reg;
   endsequence
   a_bus_ack_once: assert property (s_req |=> s_ack_pulse) // Local design decision: bus answer
      else $error("bus ack not a single cycle after request");
   a_prescale_twelve: assert property ( // (R2)
      tick12 |=> !tick12 [*8] ##1 !tick12 ##1 !tick12 ##1 !tick12 ##1 tick12)
      else $error("divide-by-12 tick period wrong");
   a_wrap_reload: assert property ( // (R3)
      (mode == ARLT_M16) && ev_hi && quiet
      |=> {cnt_hi_reg, cnt_lo_reg} == $past({rld_hi_reg, rld_lo_reg})
          && ctrl_reg[`ARLT_B_HI_OVF])
      else $error("16-bit wrap did not reload and flag");
   a_irq_overflow: assert property ( // (R4)
      ev_hi && msk_reg[`ARLT_S_HI] && clkctl_reg[`ARLT_B_TMR_IEN] && quiet
      |=> irq_o)
      else $error("overflow did not raise interrupt");
   a_split_low_free: assert property ( // (R7)
      ctrl_reg[`ARLT_B_SPLIT] && !ctrl_reg[`ARLT_B_RUN] && tick[0]
      && cnt_lo_reg != 8'hff && quiet
      |=> cnt_lo_reg == $past(cnt_lo_reg) + 8'h01
          && cnt_hi_reg == $past(cnt_hi_reg))
      else $error("split low half stalled or high half moved");
   a_flag_sticky: assert property ( // (R11)
      ctrl_reg[`ARLT_B_LO_OVF] && quiet |=> ctrl_reg[`ARLT_B_LO_OVF])
      else $error("overflow flag cleared without software");
   a_capture_copy: assert property ( // (R14)
      ev_cap |=> {rld_hi_reg, rld_lo_reg} == $past({cnt_hi_reg, cnt_lo_reg}))
      else $error("capture did not latch the count");
   a_stop_holds: assert property ( // (R17)
      !ctrl_reg[`ARLT_B_RUN] && !ctrl_reg[`ARLT_B_SPLIT] && quiet
      |=> $stable({cnt_hi_reg, cnt_lo_reg}))
      else $error("count moved while stopped");
   a_capture_zero: assert property ( // (R19)
      (mode == ARLT_MCAP16) && ev_hi && quiet
      |=> {cnt_hi_reg, cnt_lo_reg} == 16'h0000)
      else $error("capture-mode wrap did not go to zero");
   a_split_copy: assert property ( // (R15)
      (mode == ARLT_MCAPSPLIT) && ev_cap
      |=> {rld_hi_reg, rld_lo_reg} == $past({cnt_hi_reg, cnt_lo_reg}))
      else $error("split capture did not latch both halves");
   a_split_lo_flag: assert property ( // (R9)
      (mode == ARLT_MSPLIT) && ev_lo |=> ctrl_reg[`ARLT_B_LO_OVF])
      else $error("split low wrap did not set its flag");
endmodule : arlt_timer

// ### tb/arlt_timer_tb_top.sv
// Purpose: self-checking bench of the auto-reload timer with capture
// Assumes: slave answers in its own time, flags in the control register
// Notes: count figures at divided clocks are checked as ranges
`timescale 1ns/10ps
`include "arlt_defines.svh"
module auto_reload_timer_with_lfo_capture_tb_top;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic ext_clk_i = 1'b0;
   logic lfo_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic irq_o;
   logic [31:0] q;
   logic [31:0] q0;
   logic [1:0] ph = 2'h0;
   logic ext_on = 1'b0;
   int err_total = 0;
   int comparisons = 0;
   int cyc_cnt = 0;
   arlt_timer u_dut (.mclk_i(mclk_i), .reset_i(reset_i),
      .ext_clk_i(ext_clk_i), .lfo_i(lfo_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_o(irq_o));
   // Clock of 100 ns
   initial begin
      forever #50 mclk_i = ~mclk_i;
   end
   // External oscillator at a quarter of the system rate, far below sync limit
   always @(posedge mclk_i) begin
      ph <= ph + 2'h1;
      if (ext_on) ext_clk_i <= ph[1];
   end
   task automatic results();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rng(input string nm, input logic [31:0] lo,
                      input logic [31:0] hi, input logic [31:0] g);
      comparisons++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         err_total++;
         $display("BAD %s expected %h..%h seen %h", nm, lo, hi, g);
      end
   endtask : rng
   // Classic cycle: hold request until ack is sampled, then one idle cycle
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [7:0] d, input logic [3:0] s,
                     output logic [31:0] r);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {24'h0, d};
      @(posedge mclk_i);
      // Ack ends this wait; without ack only the bench timeout ends it
      while (wb_ack_o !== 1'b1) begin
         @(posedge mclk_i);
      end
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge mclk_i);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, 4'hf, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      wb(1'b0, a, 8'h00, 4'hf, r);
   endtask : rd
   // Reset values, unmapped address, write without byte lane 0
   task automatic t_reset();
      rd(`ARLT_OFS_CTRL, q); chk("ctrl", 32'h0, q); // reset stopped
      rd(`ARLT_OFS_CNT_LO, q); chk("cnt_lo", 32'h0, q); // reset
      wb(1'b1, `ARLT_OFS_RLD_LO, 8'h5a, 4'he, q);
      rd(`ARLT_OFS_RLD_LO, q); chk("rld_lo", 32'h0, q); // lane guard
      rd(8'h40, q); chk("unmapped", 32'h0, q); // decode
      chk("irq", 32'h0, {31'h0, irq_o}); // idle
   endtask : t_reset
   // Wrap near 0xffff, masked then unmasked interrupt, sticky flag
   task automatic t_wrap16();
      wr(`ARLT_OFS_RLD_LO, 8'h34); wr(`ARLT_OFS_RLD_HI, 8'h12);
      wr(`ARLT_OFS_CNT_LO, 8'hf0); wr(`ARLT_OFS_CNT_HI, 8'hff);
      wr(`ARLT_OFS_CLKCTL, 8'h05); wr(`ARLT_OFS_MASK, 8'h00);
      wr(`ARLT_OFS_CTRL, 8'h04);
      repeat (30) @(posedge mclk_i);
      // Low byte also wraps at the full wrap, so both flags rise
      rd(`ARLT_OFS_CTRL, q); chk("hi_flag", 32'hc4, q); // flag set
      chk("irq_masked", 32'h0, {31'h0, irq_o}); // mask
      wr(`ARLT_OFS_MASK, 8'h01);
      chk("irq_on", 32'h1, {31'h0, irq_o}); // overflow interrupt
      rd(`ARLT_OFS_CNT_HI, q); chk("cnt_hi", 32'h12, q); // reload
      rd(`ARLT_OFS_CNT_LO, q); rng("cnt_lo", 32'h34, 32'h60, q);
      rd(`ARLT_OFS_CTRL, q); chk("sticky", 32'hc4, q); // no self clear
      wr(`ARLT_OFS_STATUS, 8'h01); wr(`ARLT_OFS_CTRL, 8'h00);
      chk("irq_clr", 32'h0, {31'h0, irq_o}); // software clear
      // Low-byte wrap interrupt in 16-bit mode
      wr(`ARLT_OFS_CNT_LO, 8'hf8); wr(`ARLT_OFS_MASK, 8'h02);
      wr(`ARLT_OFS_CTRL, 8'h24);
      repeat (12) @(posedge mclk_i);
      chk("irq_lo16", 32'h1, {31'h0, irq_o}); // low byte wrap
      wr(`ARLT_OFS_CTRL, 8'h00); wr(`ARLT_OFS_STATUS, 8'h07);
   endtask : t_wrap16
   // Split: low half free running, high half gated by run
   task automatic t_split();
      wr(`ARLT_OFS_RLD_LO, 8'h80); wr(`ARLT_OFS_CNT_LO, 8'hf0);
      wr(`ARLT_OFS_CNT_HI, 8'h00); wr(`ARLT_OFS_MASK, 8'h03);
      wr(`ARLT_OFS_CLKCTL, 8'h07); wr(`ARLT_OFS_CTRL, 8'h28);
      repeat (30) @(posedge mclk_i);
      rd(`ARLT_OFS_CTRL, q); chk("lo_flag", 32'h68, q); // low only
      rd(`ARLT_OFS_CNT_HI, q); chk("hi_held", 32'h0, q); // gated
      rd(`ARLT_OFS_CNT_LO, q); rng("lo_rld", 32'h80, 32'ha8, q);
      chk("irq_lo", 32'h1, {31'h0, irq_o}); // either half
      wr(`ARLT_OFS_CNT_HI, 8'hfc); wr(`ARLT_OFS_CTRL, 8'h2c);
      repeat (8) @(posedge mclk_i);
      // Control write of 2c cleared the low flag; only the high wrap sets
      rd(`ARLT_OFS_CTRL, q); chk("hi_flag8", 32'hac, q);
      rd(`ARLT_OFS_CNT_HI, q); rng("hi_rld", 32'h12, 32'h20, q);
      wr(`ARLT_OFS_CTRL, 8'h00); wr(`ARLT_OFS_STATUS, 8'h07); // above
   endtask : t_split
   // Divided clocks: system by 12, external by 8
   task automatic t_div();
      wr(`ARLT_OFS_CLKCTL, 8'h04); wr(`ARLT_OFS_CNT_LO, 8'h00);
      wr(`ARLT_OFS_CNT_HI, 8'h00); wr(`ARLT_OFS_CTRL, 8'h04);
      repeat (117) @(posedge mclk_i);
      wr(`ARLT_OFS_CTRL, 8'h00);
      rd(`ARLT_OFS_CNT_LO, q); rng("div12", 32'h9, 32'hb, q);
      ext_on <= 1'b1;
      wr(`ARLT_OFS_CNT_LO, 8'h00); wr(`ARLT_OFS_CTRL, 8'h05);
      repeat (200) @(posedge mclk_i);
      wr(`ARLT_OFS_CTRL, 8'h00);
      rd(`ARLT_OFS_CNT_LO, q); rng("ext8", 32'h5, 32'h7, q);
      ext_on <= 1'b0;
   endtask : t_div
   // Capture: reserved source does nothing, falling edge copies count
   task automatic t_cap();
      wr(`ARLT_OFS_CNT_LO, 8'h00); wr(`ARLT_OFS_MASK, 8'h04);
      wr(`ARLT_OFS_CLKCTL, 8'h05); wr(`ARLT_OFS_CTRL, 8'h14);
      lfo_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      rd(`ARLT_OFS_STATUS, q); chk("css0", 32'h0, q); // reserved
      lfo_i <= 1'b1;
      wr(`ARLT_OFS_CTRL, 8'h16);
      repeat (10) @(posedge mclk_i);
      rd(`ARLT_OFS_CNT_LO, q0);
      lfo_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      rd(`ARLT_OFS_RLD_LO, q); rng("cap", q0 + 2, q0 + 7, q);
      rd(`ARLT_OFS_STATUS, q); chk("cap_st", 32'h4, q);
      chk("irq_cap", 32'h1, {31'h0, irq_o}); // interrupt
   endtask : t_cap
   // Capture-mode wrap goes to zero, not to the reload bytes
   task automatic t_capwrap();
      wr(`ARLT_OFS_STATUS, 8'h07); wr(`ARLT_OFS_RLD_HI, 8'h55);
      wr(`ARLT_OFS_CNT_HI, 8'hff); wr(`ARLT_OFS_CNT_LO, 8'hf0);
      repeat (20) @(posedge mclk_i);
      rd(`ARLT_OFS_CNT_HI, q); chk("cap_wrap_hi", 32'h0, q);
      rd(`ARLT_OFS_CTRL, q); chk("cap_flags", 32'hd6, q);
      rd(`ARLT_OFS_STATUS, q); chk("cap_ovf_st", 32'h1, q);
   endtask : t_capwrap
   // Split capture latches both running halves
   task automatic t_capsplit();
      wr(`ARLT_OFS_STATUS, 8'h07); wr(`ARLT_OFS_CTRL, 8'h1e);
      wr(`ARLT_OFS_CNT_HI, 8'h20);
      lfo_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
      rd(`ARLT_OFS_CNT_LO, q0);
      lfo_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      rd(`ARLT_OFS_RLD_HI, q); rng("cap_hi", 32'h20, 32'h22, q);
      rd(`ARLT_OFS_RLD_LO, q); rng("cap_lo", q0 + 2, q0 + 7, q);
      chk("irq_split", 32'h1, {31'h0, irq_o}); // interrupt
   endtask : t_capsplit
   // Main sequence
   initial begin
      repeat (8) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      // Scenarios race a cycle ceiling; a hang counts as a mismatch
      fork
         begin
            t_reset();
            t_wrap16();
            t_split();
            t_div();
            t_cap();
            t_capwrap();
            t_capsplit();
         end
         begin
            while (cyc_cnt < 6000) begin
               @(posedge mclk_i);
               cyc_cnt++;
            end
            err_total++;
         end
      join_any
      results();
   end
endmodule : auto_reload_timer_with_lfo_capture_tb_top
